/* spwt_pkg.sv */
// package: register map, reset values and timing constants
package spwt_pkg;
	localparam int unsigned SPWT_ADDR_W = 8;
	localparam logic [7:0] SPWT_OFS_SIGDET_SAT = 8'h24;
	localparam logic [7:0] SPWT_OFS_LEVEL_OBS = 8'h25;
	localparam logic [7:0] SPWT_OFS_SYNC_SEARCH = 8'h26;
	localparam logic [7:0] SPWT_OFS_SYNC_TIMEOUT = 8'h27;
	localparam logic [7:0] SPWT_OFS_CONTROL = 8'h2d;
	localparam logic [7:0] SPWT_OFS_STATUS = 8'h2e;
	localparam logic [7:0] SPWT_RST_SIGDET_SAT = 8'h10;
	localparam logic [7:0] SPWT_RST_LEVEL_OBS = 8'h00;
	localparam logic [7:0] SPWT_RST_SYNC_SEARCH = 8'h87;
	localparam logic [7:0] SPWT_RST_SYNC_TIMEOUT = 8'hff;
	localparam int unsigned SPWT_PS_CODE_MSB = 7;
	localparam int unsigned SPWT_PS_CODE_LSB = 5;
	localparam int unsigned SPWT_OBS_CNT_MSB = 4;
	// base prescale is 4 = 2**2, so factor = 1 << (code + 2)
	localparam int unsigned SPWT_PS_BASE_LOG2 = 2;
	localparam int unsigned SPWT_OBS_TICK = 64;
	localparam int unsigned SPWT_SYNC_TICK = 64 * 512;
	localparam int unsigned SPWT_ZERO_OBS_COUNT = 32;
	localparam int unsigned SPWT_CLK_NS = 10;
	localparam int unsigned SPWT_SIXTEENTHS_PER_BIT = 16;
	localparam int unsigned SPWT_CNT_W = 24;
	typedef enum logic [1:0] {SPWT_ST_IDLE, SPWT_ST_POLL, SPWT_ST_RUN}
		spwt_mode_e;
endpackage : spwt_pkg

/* spwt_tick_if.sv */
// interface: tick prescaler configuration and outputs
`timescale 1ns/10ps
interface spwt_tick_if;
	logic run;
	logic clear;
	logic [2:0] ps_code;
	logic obs_tick;
	logic sync_tick;
	modport gen (input run, input clear, input ps_code, output obs_tick,
		output sync_tick);
	modport use_side (output run, output clear, output ps_code,
		input obs_tick, input sync_tick);
endinterface : spwt_tick_if

/* spwt_prescaler.sv */
// prescaler: divides the system clock into observation and sync ticks
`timescale 1ns/10ps
module spwt_prescaler
	import spwt_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	spwt_tick_if.gen tk
);
	localparam logic [15:0] OBS_TICK_M1 = 16'(SPWT_OBS_TICK - 1);
	localparam logic [15:0] SYNC_TICK_M1 = 16'(SPWT_SYNC_TICK - 1);
	logic [15:0] obs_div_reg, obs_div_next;
	logic [15:0] sync_div_reg, sync_div_next;
	logic [15:0] obs_limit;
	logic obs_wrap, sync_wrap;
	////////////////////////////////////////////////////////////////////
	always_comb
	begin
		// counter wraps at factor * 64 - 1, so factor * 64 clock periods per observation tick
		obs_limit = 16'((32'd1 << (32'(tk.ps_code) + SPWT_PS_BASE_LOG2))
			* SPWT_OBS_TICK - 1);
		obs_wrap = tk.run && (obs_div_reg == obs_limit);
		sync_wrap = tk.run && (sync_div_reg == SYNC_TICK_M1);
		obs_div_next = obs_div_reg;
		sync_div_next = sync_div_reg;
		if (tk.clear || !tk.run)
		begin
			obs_div_next = '0;
			sync_div_next = '0;
		end
		else
		begin
			obs_div_next = obs_wrap ? 16'h0000 : obs_div_reg + 16'h0001;
			sync_div_next = sync_wrap ? 16'h0000 : sync_div_reg + 16'h0001;
		end
	end
	assign tk.obs_tick = obs_wrap && !tk.clear;
	assign tk.sync_tick = sync_wrap && !tk.clear;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			obs_div_reg <= '0;
			sync_div_reg <= '0;
		end
		else
		begin
			obs_div_reg <= obs_div_next;
			sync_div_reg <= sync_div_next;
		end
	end
	// unused constant kept for symmetry of tick limits
	logic [15:0] unused_obs_m1;
	assign unused_obs_m1 = OBS_TICK_M1;
endmodule : spwt_prescaler

/* spwt_timers.sv */
// top: wake-up and self-polling supervision timers with wishbone registers
// Notes on behaviour
// - An 8-bit register, reset 0x10, supplies the peak saturation threshold output.
// - Prescale code 0..7 selects factor 4,8,...,512, reset code 0.
// - Observation count N of 1..31 gives N times factor times 64 clocks.
// - Observation count 0 (reset value) counts as 32.
// - Sync search limit counts sixteenths of a bit, 0 is none, reset 0x87.
// - In run-mode self polling the sync timer expiring without sync returns to self polling.
// - The sync timer reloads from its value at each new run-mode cycle.
// - Sync timeout is value times 64 times 512 clocks, 0 leaves the timer stopped.
`timescale 1ns/10ps
module spwt_timers
	import spwt_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [spwt_pkg::SPWT_ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic run_cycle_start,
	input wire logic symbol_sync_found,
	input wire logic obs_start,
	input wire logic bit_sixteenth_strobe,
	input wire logic search_start,
	output logic [7:0] peak_saturation_threshold,
	output logic run_mode_active,
	output logic sync_timeout_pulse,
	output logic obs_active,
	output logic obs_done,
	output logic search_active,
	output logic search_expired
);
	import spwt_pkg::*;
	logic [7:0] sat_reg, sat_next;
	logic [7:0] lot_reg, lot_next;
	logic [7:0] srch_reg, srch_next;
	logic [7:0] tos_reg, tos_next;
	logic [1:0] ctl_reg, ctl_next;
	logic ack_reg, ack_next;
	logic err_reg, err_next;
	logic [31:0] rdat_reg, rdat_next;
	spwt_mode_e mode_reg, mode_next;
	logic [7:0] sync_cnt_reg, sync_cnt_next;
	logic [5:0] obs_cnt_reg, obs_cnt_next;
	logic obs_act_reg, obs_act_next;
	logic obs_done_reg, obs_done_next;
	logic tmo_reg, tmo_next;
	logic [7:0] srch_cnt_reg, srch_cnt_next;
	logic srch_act_reg, srch_act_next;
	logic srch_exp_reg, srch_exp_next;
	logic req, wr_hit, lane0;
	logic mapped;
	logic [2:0] observation_prescale_code;
	logic [4:0] observation_count;
	logic [7:0] sync_search_limit;
	logic [7:0] sync_timeout_value;
	spwt_tick_if tk ();
	////////////////////////////////////////////////////////////////////
	// tick generation
	spwt_prescaler u_prescaler (
		.clk(clk),
		.reset_n(reset_n),
		.tk(tk.gen)
	);
	assign observation_prescale_code =
		lot_reg[SPWT_PS_CODE_MSB:SPWT_PS_CODE_LSB];
	assign observation_count = lot_reg[SPWT_OBS_CNT_MSB:0];
	assign sync_search_limit = srch_reg;
	assign sync_timeout_value = tos_reg;
	assign tk.ps_code = observation_prescale_code;
	assign tk.run = obs_act_reg || (mode_reg == SPWT_ST_RUN);
	assign tk.clear = obs_start || run_cycle_start;
	////////////////////////////////////////////////////////////////////
	// wishbone register slave
	always_comb
	begin
		req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
		mapped = (wb_adr_i == SPWT_OFS_SIGDET_SAT) ||
			(wb_adr_i == SPWT_OFS_LEVEL_OBS) ||
			(wb_adr_i == SPWT_OFS_SYNC_SEARCH) ||
			(wb_adr_i == SPWT_OFS_SYNC_TIMEOUT) ||
			(wb_adr_i == SPWT_OFS_CONTROL) ||
			(wb_adr_i == SPWT_OFS_STATUS);
		lane0 = wb_sel_i[0];
		wr_hit = req && mapped && wb_we_i && lane0;
		ack_next = req && mapped;
		err_next = req && !mapped;
		sat_next = sat_reg;
		lot_next = lot_reg;
		srch_next = srch_reg;
		tos_next = tos_reg;
		ctl_next = ctl_reg;
		rdat_next = rdat_reg;
		if (wr_hit)
		begin
			case (wb_adr_i)
				SPWT_OFS_SIGDET_SAT: sat_next = wb_dat_i[7:0];
				SPWT_OFS_LEVEL_OBS: lot_next = wb_dat_i[7:0];
				SPWT_OFS_SYNC_SEARCH: srch_next = wb_dat_i[7:0];
				SPWT_OFS_SYNC_TIMEOUT: tos_next = wb_dat_i[7:0];
				SPWT_OFS_CONTROL: ctl_next = wb_dat_i[1:0];
				default: ;
			endcase
		end
		if (req && mapped && !wb_we_i)
		begin
			case (wb_adr_i)
				SPWT_OFS_SIGDET_SAT: rdat_next = {24'h000000, sat_reg};
				SPWT_OFS_LEVEL_OBS: rdat_next = {24'h000000, lot_reg};
				SPWT_OFS_SYNC_SEARCH: rdat_next = {24'h000000, srch_reg};
				SPWT_OFS_SYNC_TIMEOUT: rdat_next = {24'h000000, tos_reg};
				SPWT_OFS_CONTROL: rdat_next = {30'h00000000, ctl_reg};
				SPWT_OFS_STATUS: rdat_next = {24'h000000, sync_cnt_reg[1:0],
					srch_exp_reg, srch_act_reg, obs_done_reg, obs_act_reg,
					mode_reg};
				default: rdat_next = '0;
			endcase
		end
		else if (req)
			rdat_next = '0;
	end
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sat_reg <= SPWT_RST_SIGDET_SAT;
			lot_reg <= SPWT_RST_LEVEL_OBS;
			srch_reg <= SPWT_RST_SYNC_SEARCH;
			tos_reg <= SPWT_RST_SYNC_TIMEOUT;
			ctl_reg <= '0;
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdat_reg <= '0;
		end
		else
		begin
			sat_reg <= sat_next;
			lot_reg <= lot_next;
			srch_reg <= srch_next;
			tos_reg <= tos_next;
			ctl_reg <= ctl_next;
			ack_reg <= ack_next;
			err_reg <= err_next;
			rdat_reg <= rdat_next;
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign wb_dat_o = rdat_reg;
	assign peak_saturation_threshold = sat_reg;
	////////////////////////////////////////////////////////////////////
	// self-polling mode and symbol-sync timeout
	always_comb
	begin
		mode_next = mode_reg;
		sync_cnt_next = sync_cnt_reg;
		tmo_next = 1'b0;
		case (mode_reg)
			SPWT_ST_IDLE:
			begin
				if (ctl_reg[0])
					mode_next = SPWT_ST_POLL;
			end
			SPWT_ST_POLL:
			begin
				if (!ctl_reg[0])
					mode_next = SPWT_ST_IDLE;
				else if (run_cycle_start)
				begin
					mode_next = SPWT_ST_RUN;
					sync_cnt_next = sync_timeout_value;
				end
			end
			SPWT_ST_RUN:
			begin
				if (!ctl_reg[0])
					mode_next = SPWT_ST_IDLE;
				else if (run_cycle_start)
					sync_cnt_next = sync_timeout_value;
				else if (symbol_sync_found)
					mode_next = SPWT_ST_POLL;
				else if (sync_timeout_value != 8'h00 && tk.sync_tick)
				begin
					// value zero leaves the timer stopped
					if (sync_cnt_reg <= 8'h01)
					begin
						mode_next = SPWT_ST_POLL;
						tmo_next = 1'b1;
						sync_cnt_next = 8'h00;
					end
					else
						sync_cnt_next = sync_cnt_reg - 8'h01;
				end
			end
			default: mode_next = SPWT_ST_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode_reg <= SPWT_ST_IDLE;
			sync_cnt_reg <= '0;
			tmo_reg <= 1'b0;
		end
		else
		begin
			mode_reg <= mode_next;
			sync_cnt_reg <= sync_cnt_next;
			tmo_reg <= tmo_next;
		end
	end
	assign run_mode_active = (mode_reg == SPWT_ST_RUN);
	assign sync_timeout_pulse = tmo_reg;
	////////////////////////////////////////////////////////////////////
	// level observation timer and sync search timer
	always_comb
	begin
		obs_cnt_next = obs_cnt_reg;
		obs_act_next = obs_act_reg;
		obs_done_next = 1'b0;
		if (obs_start)
		begin
			obs_act_next = 1'b1;
			obs_cnt_next = (observation_count == 5'h00) ?
				6'(SPWT_ZERO_OBS_COUNT) : {1'b0, observation_count};
		end
		else if (obs_act_reg && tk.obs_tick)
		begin
			if (obs_cnt_reg == 6'h01)
			begin
				obs_act_next = 1'b0;
				obs_done_next = 1'b1;
			end
			obs_cnt_next = obs_cnt_reg - 6'h01;
		end
		srch_cnt_next = srch_cnt_reg;
		srch_act_next = srch_act_reg;
		srch_exp_next = 1'b0;
		if (search_start)
		begin
			// zero limit: no search time at all
			srch_act_next = (sync_search_limit != 8'h00);
			srch_exp_next = (sync_search_limit == 8'h00);
			srch_cnt_next = sync_search_limit;
		end
		else if (srch_act_reg && bit_sixteenth_strobe)
		begin
			if (srch_cnt_reg == 8'h01)
			begin
				srch_act_next = 1'b0;
				srch_exp_next = 1'b1;
			end
			srch_cnt_next = srch_cnt_reg - 8'h01;
		end
	end
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			obs_cnt_reg <= '0;
			obs_act_reg <= 1'b0;
			obs_done_reg <= 1'b0;
			srch_cnt_reg <= '0;
			srch_act_reg <= 1'b0;
			srch_exp_reg <= 1'b0;
		end
		else
		begin
			obs_cnt_reg <= obs_cnt_next;
			obs_act_reg <= obs_act_next;
			obs_done_reg <= obs_done_next;
			srch_cnt_reg <= srch_cnt_next;
			srch_act_reg <= srch_act_next;
			srch_exp_reg <= srch_exp_next;
		end
	end
	assign obs_active = obs_act_reg;
	assign obs_done = obs_done_reg;
	assign search_active = srch_act_reg;
	assign search_expired = srch_exp_reg;
endmodule : spwt_timers

/* spwt_timers_chk.sv */
// checker: bus and timer relations at the ports of the supervision timers
`timescale 1ns/10ps
module spwt_timers_chk
	import spwt_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [spwt_pkg::SPWT_ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic run_cycle_start,
	input wire logic symbol_sync_found,
	input wire logic obs_start,
	input wire logic search_start,
	input wire logic [7:0] peak_saturation_threshold,
	input wire logic run_mode_active,
	input wire logic sync_timeout_pulse,
	input wire logic obs_active,
	input wire logic obs_done,
	input wire logic search_active,
	input wire logic search_expired
);
	logic req;
	logic mapped;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign mapped = wb_adr_i inside {SPWT_OFS_SIGDET_SAT, SPWT_OFS_LEVEL_OBS,
		SPWT_OFS_SYNC_SEARCH, SPWT_OFS_SYNC_TIMEOUT, SPWT_OFS_CONTROL,
		SPWT_OFS_STATUS};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////
	a_bus_ack: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
		else $error("mapped request not acknowledged");
	a_bus_err: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
		else $error("unmapped request not refused");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_thr_reset: assert property ($rose(reset_n) |->
		peak_saturation_threshold == SPWT_RST_SIGDET_SAT)
		else $error("threshold not at reset value");
	a_timeout_poll: assert property ($rose(sync_timeout_pulse) |->
		!run_mode_active && $past(run_mode_active))
		else $error("timeout outside run mode");
	a_timeout_once: assert property (sync_timeout_pulse |=>
		!sync_timeout_pulse)
		else $error("timeout pulse too long");
	a_sync_leave: assert property (run_mode_active &&
		symbol_sync_found && !run_cycle_start |=> !run_mode_active)
		else $error("sync found but run mode kept");
	a_obs_start: assert property (obs_start |=> obs_active)
		else $error("observation not started");
	a_done_once: assert property (obs_done |=> !obs_done)
		else $error("observation done too long");
	a_search_run: assert property (search_start |=>
		search_active || search_expired)
		else $error("search not started");
	c_ack: cover property (wb_ack_o);
	c_err: cover property (wb_err_o);
	c_timeout: cover property (sync_timeout_pulse);
	c_obs: cover property (obs_done);
endmodule : spwt_timers_chk

bind spwt_timers spwt_timers_chk chk_u (.*);

/* spwt_tb.sv */
// testbench: register, observation, search and sync timeout checks
`timescale 1ns/10ps
module testbench;
	import spwt_pkg::*;
	logic clk, reset_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
	logic [7:0] wb_adr_i, peak_saturation_threshold;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i;
	logic run_cycle_start, symbol_sync_found, obs_start, search_start;
	logic bit_sixteenth_strobe, run_mode_active, sync_timeout_pulse;
	logic obs_active, obs_done, search_active, search_expired;
	logic [2:0] tick;
	logic [15:0] rnd;
	int fails, cmp_count;
	int m [4];
	spwt_timers dut_u (.*);
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// sixteenth-bit strobe every eight clocks
	always @(posedge clk)
	begin
		tick <= tick + 3'h1;
		bit_sixteenth_strobe <= (tick == 3'h0);
	end
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic e);
		int n;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
		q = wb_dat_o[7:0];
		e = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 50)
			fails++;
	endtask : wb
	// k selects observation, search or run cycle; c counts clocks, s strobes
	task automatic timed(input int k, input int lim, output int c, output int s);
		@(posedge clk);
		obs_start <= (k == 0);
		search_start <= (k == 1);
		run_cycle_start <= (k == 2);
		@(posedge clk);
		obs_start <= 1'b0;
		search_start <= 1'b0;
		run_cycle_start <= 1'b0;
		c = 1;
		s = 0;
		while (c < lim && !(k == 0 ? obs_done === 1'b1 : k == 1 ?
			search_expired === 1'b1 : sync_timeout_pulse === 1'b1))
		begin
			s += (bit_sixteenth_strobe === 1'b1);
			@(posedge clk);
			c++;
		end
	endtask : timed
	////////////////////////////////////////////////////////////////////////
	// about 60k cycles are expected; the limit leaves ample margin
	initial
	begin
		#1000000;
		fails++;
		print_verdict();
	end
	initial
	begin
		logic [7:0] q;
		logic e;
		logic [7:0] ov [4];
		int c, s, n;
		{wb_we_i, wb_cyc_i, wb_stb_i, run_cycle_start, symbol_sync_found} = '0;
		{obs_start, search_start, reset_n, tick} = '0;
		wb_adr_i = 8'h0;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hf;
		m = '{16, 0, 135, 255};
		ov = '{8'h00, 8'h01, 8'h21, 8'h42};
		rnd = 16'd63738;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			wb(1'b0, 8'h24 + i[7:0], 8'h0, q, e);
			chk(q, m[i]);
			rnd = lfsr(rnd);
			m[i] = rnd[7:0];
			wb(1'b1, 8'h24 + i[7:0], rnd[7:0], q, e);
			wb(1'b0, 8'h24 + i[7:0], 8'h0, q, e);
			chk(q, m[i]);
		end
		chk(peak_saturation_threshold, m[0]);
		wb(1'b0, 8'h30, 8'h0, q, e);
		chk(e, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			wb(1'b1, 8'h25, ov[i], q, e);
			n = (ov[i][4:0] == 0 ? 32 : ov[i][4:0]) * (4 << ov[i][7:5]) * 64;
			timed(0, 40000, c, s);
			chk(c >= n - 1 && c <= n + 3, 1'b1);
			chk(obs_active, 1'b0);
		end
		for (int i = 0; i < 3; i++)
		begin
			n = i == 0 ? 0 : i == 1 ? 3 : rnd[3:0];
			wb(1'b1, 8'h26, n[7:0], q, e);
			timed(1, 400, c, s);
			chk(s >= n && s <= n + 1, 1'b1);
			chk(search_active, 1'b0);
		end
		wb(1'b1, 8'h2d, 8'h01, q, e);
		wb(1'b1, 8'h27, 8'h01, q, e);
		timed(2, 16000, c, s);
		chk(run_mode_active, 1'b1);
		timed(2, 40000, c, s);
		chk(c >= 32766 && c <= 32772, 1'b1);
		chk(run_mode_active, 1'b0);
		timed(2, 4, c, s);
		symbol_sync_found <= 1'b1;
		@(posedge clk);
		symbol_sync_found <= 1'b0;
		repeat (2) @(posedge clk);
		chk(run_mode_active, 1'b0);
		wb(1'b1, 8'h27, 8'h00, q, e);
		timed(2, 3000, c, s);
		chk(c, 3000);
		chk(run_mode_active, 1'b1);
		print_verdict();
	end
endmodule : testbench
